// ### hw/e1_rx_pkg.sv
// Shared constants and state types for the E1 receive slip buffer and framer.
// Assumes a single pclk domain; link clocks arrive as sampled inputs.
package e1_rx_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   // Control field positions and reset value
   localparam int CTRL_MASK_BIT = 0;
   localparam int CTRL_AUTO_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   // Status field positions
   localparam int ST_TOGGLE_BIT = 0;
   localparam int ST_DIR_BIT = 1;
   localparam int ST_BASIC_BIT = 2;
   localparam int ST_SIG_BIT = 3;
   localparam int ST_CRC_BIT = 4;
   localparam int ST_NONCRC_BIT = 5;
   localparam int ST_PEND_BIT = 6;
   // Line patterns
   localparam logic [6:0] FAS_PATTERN = 7'h1b;
   localparam logic [3:0] MFAS_NIBBLE = 4'h0;
   localparam logic [5:0] CRC_MFAS = 6'h0b;
   // Bit positions inside a 256-bit frame
   localparam logic [7:0] TS0_END = 8'h07;
   localparam logic [7:0] TS16_NIBBLE_END = 8'h83;
   localparam logic [7:0] FRAME_END = 8'hff;
   // Slip buffer geometry, in channels
   localparam int BUF_CHANNELS = 64;
   localparam logic [5:0] UNDER_LIMIT = 6'h02;
   localparam logic [5:0] OVER_LIMIT = 6'h3c;
   localparam logic [5:0] RESET_READ_CH = 6'h20;
   localparam logic [5:0] HALF_BUF = 6'h20;
   // Framing counts and times
   localparam logic [1:0] FAS_LOSS_COUNT = 2'h3;
   localparam int FRAME_US = 125;
   localparam int CRC_WINDOW_MS = 8;
   localparam int CRC_WINDOW_FRAMES = (CRC_WINDOW_MS * 1000) / FRAME_US;
   localparam int CRC_TIMEOUT_MS = 400;
   localparam int CRC_TIMEOUT_FRAMES = (CRC_TIMEOUT_MS * 1000) / FRAME_US;
   // State types
   typedef enum logic [1:0] {F_HUNT, F_NFAS, F_FAS, F_SYNC} framer_state_t;
   typedef enum logic {S_SEARCH, S_LOCK} sig_state_t;
   typedef enum logic [1:0] {C_SEARCH, C_FIRST, C_SYNC, C_NONCRC} crc_state_t;
endpackage

// ### hw/e1_rx_slip_framer.sv
// E1 receive path: basic, signalling and CRC-4 framers, two-frame slip buffer, APB regs.
// Assumes both link clocks are far slower than pclk and arrive asynchronously.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Two-frame slip buffer sits between line side and backplane side.
// - Buffer written on recovered clock edges, read on backplane clock edges.
// - Up to 26 channels of wander absorbed before any slip.
// - Unslipped delay stays between about two and sixty channels.
// - Out-of-window spacing repeats or drops exactly one whole frame.
// - Slips happen only on read frame boundaries.
// - Slip toggle flag inverts on every slip.
// - Direction flag 0 after dropped frame, 1 after repeated frame.
// - Slip raises a maskable interrupt source.
// - Read within two channels of write slips to about 34 channels.
// - Read beyond sixty channels slips to about 28 channels.
// - Hunt for FAS, then restart if following NFAS bit 2 is zero.
// - Basic sync declared after NFAS bit 2 one and next FAS correct.
// - Multiframe searches run only while basic alignment holds.
// - Signalling lock on first zero nibble in channel 16 upper half.
// - Two consecutive bad signalling multiframes drop signalling lock.
// - CRC-4 search looks for 001011 in NFAS bit one.
// - Two good CRC-4 alignments within 8 ms declare CRC sync.
// - Timeout without CRC sync suspends receive CRC, keeps E-bits zero, flags.
// - Automatic interworking active while the disable bit is zero.
// - Three consecutive bad FAS words restart all framing.
// - Outgoing RAI is one while basic alignment is absent, zero while it holds.
module e1_rx_slip_framer
   import e1_rx_pkg::*;
#(
   parameter int TIMEOUT_FRAMES = CRC_TIMEOUT_FRAMES
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic rx_recovered_clock, // Clock recovered from line
   input wire logic rx_line_data, // Line data, valid at recovered clock rise
   input wire logic backplane_bit_clock, // Backplane bit clock
   output logic bp_data, // Backplane serial data
   output logic bp_frame, // High during first bit of a read frame
   output logic tx_rai, // Outgoing remote alarm bit
   output logic tx_ebit_zero, // Force outgoing E-bits to zero
   output logic crc_rx_active, // Receive CRC-4 checking enabled
   output logic slip_irq // Slip interrupt, active high
);
   logic [1:0] rxc_s, rxd_s, bpc_s;
   logic rxc_d, bpc_d, rx_edge, bp_edge;
   logic [7:0] sr, nsr, bitpos, rsr;
   framer_state_t fstate;
   sig_state_t sstate;
   crc_state_t cstate;
   logic fas_expect, basic_sync, hunt_found, sig_err;
   logic [1:0] fas_err;
   logic [3:0] sig_frame;
   logic [5:0] crc_sr, wptr, waddr, rch, next_ch, delay;
   logic [6:0] crc_age;
   logic [11:0] crc_timer;
   logic [7:0] mem [BUF_CHANNELS];
   logic [2:0] rbit;
   logic frame_wrap, under, over, slip_ev;
   logic slip_toggle_flag, slip_direction_flag, slip_pending;
   logic slip_interrupt_mask, auto_interwork_disable;
   logic apb_setup, apb_write, mapped;
   logic [31:0] status_word;

   // Seven FAS bits check
   function automatic logic fas_ok(input logic [7:0] b);
      return b[6:0] == FAS_PATTERN;
   endfunction

   // Two-stage synchronisers plus edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxc_s <= 2'h0;
         rxd_s <= 2'h0;
         bpc_s <= 2'h0;
         rxc_d <= 1'b0;
         bpc_d <= 1'b0;
      end else begin
         rxc_s <= {rxc_s[0], rx_recovered_clock};
         rxd_s <= {rxd_s[0], rx_line_data};
         bpc_s <= {bpc_s[0], backplane_bit_clock};
         rxc_d <= rxc_s[1];
         bpc_d <= bpc_s[1];
      end
   end

   // Edge strobes and received shift value
   assign rx_edge = rxc_s[1] & ~rxc_d;
   assign bp_edge = bpc_s[1] & ~bpc_d;
   assign nsr = {sr[6:0], rxd_s[1]};
   assign basic_sync = (fstate == F_SYNC);
   assign hunt_found = (fstate == F_HUNT) && fas_ok(nsr);

   // Receive shift register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr <= 8'h00;
      end else if (rx_edge) begin
         sr <= nsr;
      end
   end

   // Basic frame alignment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fstate <= F_HUNT;
         bitpos <= 8'h00;
         fas_expect <= 1'b0;
         fas_err <= 2'h0;
      end else if (rx_edge) begin
         bitpos <= bitpos + 8'h01;
         unique case (fstate)
            F_HUNT: begin
               if (hunt_found) begin
                  fstate <= F_NFAS;
                  bitpos <= TS0_END + 8'h01;
               end
            end
            F_NFAS: begin
               if (bitpos == TS0_END) begin
                  fstate <= nsr[6] ? F_FAS : F_HUNT;
               end
            end
            F_FAS: begin
               if (bitpos == TS0_END) begin
                  fstate <= fas_ok(nsr) ? F_SYNC : F_HUNT;
                  fas_expect <= 1'b0;
                  fas_err <= 2'h0;
               end
            end
            F_SYNC: begin
               if (bitpos == TS0_END) begin
                  fas_expect <= ~fas_expect;
                  // three bad FAS words lose sync
                  if (fas_expect) begin
                     if (fas_ok(nsr)) begin
                        fas_err <= 2'h0;
                     end else if (fas_err == FAS_LOSS_COUNT - 2'h1) begin
                        fstate <= F_HUNT;
                     end else begin
                        fas_err <= fas_err + 2'h1;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Signalling multiframe alignment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sstate <= S_SEARCH;
         sig_frame <= 4'h0;
         sig_err <= 1'b0;
      end else if (!basic_sync) begin
         // held in search without basic sync
         sstate <= S_SEARCH;
         sig_frame <= 4'h0;
         sig_err <= 1'b0;
      end else if (rx_edge) begin
         if (bitpos == FRAME_END) begin
            sig_frame <= sig_frame + 4'h1;
         end
         if (bitpos == TS16_NIBBLE_END) begin
            unique case (sstate)
               S_SEARCH: begin
                  if (nsr[3:0] == MFAS_NIBBLE) begin
                     sstate <= S_LOCK;
                     sig_frame <= 4'h0;
                     sig_err <= 1'b0;
                  end
               end
               S_LOCK: begin
                  // two bad multiframes in a row
                  if (sig_frame == 4'h0) begin
                     if (nsr[3:0] == MFAS_NIBBLE) begin
                        sig_err <= 1'b0;
                     end else if (sig_err) begin
                        sstate <= S_SEARCH;
                     end else begin
                        sig_err <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // CRC-4 multiframe alignment and interworking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cstate <= C_SEARCH;
         crc_sr <= 6'h00;
         crc_age <= 7'h00;
         crc_timer <= 12'h000;
      end else if (!basic_sync) begin
         // CRC search waits for basic sync
         cstate <= C_SEARCH;
         crc_sr <= 6'h00;
         crc_age <= 7'h00;
         crc_timer <= 12'h000;
      end else if (rx_edge) begin
         if (bitpos == FRAME_END) begin
            crc_age <= crc_age + 7'h01;
            if (crc_timer != 12'(TIMEOUT_FRAMES)) begin
               crc_timer <= crc_timer + 12'h001;
            end
         end
         // second alignment must come within 8 ms
         if (cstate == C_FIRST && crc_age == 7'(CRC_WINDOW_FRAMES)) begin
            cstate <= C_SEARCH;
         end
         if (bitpos == TS0_END && !fas_expect) begin
            crc_sr <= {crc_sr[4:0], nsr[7]};
            if ({crc_sr[4:0], nsr[7]} == CRC_MFAS) begin
               if (cstate == C_SEARCH) begin
                  cstate <= C_FIRST;
                  crc_age <= 7'h00;
               end else if (cstate == C_FIRST && crc_age[3:0] == 4'h0 && crc_age != 7'h00) begin
                  cstate <= C_SYNC;
               end
            end
         end
         // far end treated as non-CRC after timeout
         if (crc_timer == 12'(TIMEOUT_FRAMES) && !auto_interwork_disable &&
             (cstate == C_SEARCH || cstate == C_FIRST)) begin
            cstate <= C_NONCRC;
         end
      end
   end

   // Slip buffer write side, one byte per channel
   assign waddr = hunt_found ? {wptr[5], 5'h00} : wptr;

   always_ff @(posedge pclk) begin
      if (rx_edge && (bitpos[2:0] == 3'h7 || hunt_found)) begin
         mem[waddr] <= nsr;
      end
   end

   // Write pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr <= 6'h00;
      end else if (rx_edge && (bitpos[2:0] == 3'h7 || hunt_found)) begin
         wptr <= waddr + 6'h01;
      end
   end

   // Read spacing and slip decision
   assign next_ch = rch + 6'h01;
   assign delay = wptr - rch;
   assign frame_wrap = bp_edge && rbit == 3'h7 && next_ch[4:0] == 5'h00;
   assign under = delay <= UNDER_LIMIT;
   assign over = delay > OVER_LIMIT;
   assign slip_ev = frame_wrap && (under || over);

   // Read side toward backplane
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rch <= RESET_READ_CH;
         rbit <= 3'h0;
         rsr <= 8'h00;
         bp_data <= 1'b0;
         bp_frame <= 1'b0;
      end else if (bp_edge) begin
         rbit <= rbit + 3'h1;
         if (rbit == 3'h7) begin
            // a slip moves read by one whole frame
            // window edges give 26 channels of margin
            rch <= slip_ev ? (next_ch ^ HALF_BUF) : next_ch;
            rsr <= mem[slip_ev ? (next_ch ^ HALF_BUF) : next_ch];
            bp_data <= mem[slip_ev ? (next_ch ^ HALF_BUF) : next_ch][7];
            bp_frame <= (next_ch[4:0] == 5'h00);
         end else begin
            rsr <= {rsr[6:0], 1'b0};
            bp_data <= rsr[6];
            bp_frame <= 1'b0;
         end
      end
   end

   // APB decode
   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite && pready && !pslverr;
   assign mapped = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR);

   // Slip status flags, set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slip_toggle_flag <= 1'b0;
         slip_direction_flag <= 1'b0;
         slip_pending <= 1'b0;
      end else if (slip_ev) begin
         slip_toggle_flag <= ~slip_toggle_flag;
         slip_direction_flag <= under;
         slip_pending <= 1'b1;
      end else if (apb_write && paddr == STATUS_ADDR && pwdata[ST_PEND_BIT]) begin
         slip_pending <= 1'b0;
      end
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slip_interrupt_mask <= CTRL_RESET[CTRL_MASK_BIT];
         auto_interwork_disable <= CTRL_RESET[CTRL_AUTO_BIT];
      end else if (apb_write && paddr == CTRL_ADDR) begin
         slip_interrupt_mask <= pwdata[CTRL_MASK_BIT];
         auto_interwork_disable <= pwdata[CTRL_AUTO_BIT];
      end
   end

   // Status word assembly
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_TOGGLE_BIT] = slip_toggle_flag;
      status_word[ST_DIR_BIT] = slip_direction_flag;
      status_word[ST_BASIC_BIT] = !basic_sync;
      status_word[ST_SIG_BIT] = (sstate != S_LOCK);
      status_word[ST_CRC_BIT] = (cstate != C_SYNC);
      status_word[ST_NONCRC_BIT] = (cstate == C_NONCRC);
      status_word[ST_PEND_BIT] = slip_pending;
   end

   // APB answer, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (apb_setup) begin
            pslverr <= !mapped;
            if (paddr == CTRL_ADDR) begin
               prdata <= {30'h0, auto_interwork_disable, slip_interrupt_mask};
            end else if (paddr == STATUS_ADDR) begin
               prdata <= status_word;
            end else begin
               prdata <= 32'h0000_0000;
            end
         end
      end
   end

   // Line-side and interrupt outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_rai <= 1'b1;
         tx_ebit_zero <= 1'b1;
         crc_rx_active <= 1'b1;
         slip_irq <= 1'b0;
      end else begin
         tx_rai <= !basic_sync;
         tx_ebit_zero <= (cstate != C_SYNC);
         crc_rx_active <= (cstate != C_NONCRC);
         slip_irq <= slip_pending && !slip_interrupt_mask;
      end
   end

   // Checks
   slip_boundary_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(slip_toggle_flag) |-> $past(frame_wrap))
      else $error("slip off frame boundary");
   toggle_on_slip_a: assert property (@(posedge pclk) disable iff (!presetn)
      slip_ev |=> slip_toggle_flag != $past(slip_toggle_flag))
      else $error("toggle flag missed slip");
   dir_repeat_a: assert property (@(posedge pclk) disable iff (!presetn)
      slip_ev && under |=> slip_direction_flag)
      else $error("direction wrong after repeat");
   dir_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      slip_ev && over |=> !slip_direction_flag)
      else $error("direction wrong after drop");
   under_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
      slip_ev && under && !rx_edge |=> delay >= 6'h20 && delay <= 6'h22)
      else $error("bad spacing after underflow slip");
   over_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
      slip_ev && over && !rx_edge |=> delay >= 6'h1c && delay <= 6'h1f)
      else $error("bad spacing after overflow slip");
   irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
      slip_ev && !slip_interrupt_mask ##1 !slip_interrupt_mask |=> slip_irq)
      else $error("slip interrupt not raised");
   irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      slip_irq && slip_pending && !slip_interrupt_mask && !apb_write |=> ##1 slip_irq)
      else $error("slip interrupt dropped early");
   mf_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
      !basic_sync |=> sstate == S_SEARCH && cstate == C_SEARCH)
      else $error("multiframe search without basic sync");
   sync_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(basic_sync) |-> $past(fstate) == F_FAS)
      else $error("basic sync skipped confirmation");
   rai_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      basic_sync [*2] |-> !tx_rai)
      else $error("RAI high while aligned");
   noncrc_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      auto_interwork_disable && $past(auto_interwork_disable) |-> !$rose(cstate == C_NONCRC))
      else $error("interworking while disabled");

   cover property (@(posedge pclk) disable iff (!presetn) slip_ev && under);
   cover property (@(posedge pclk) disable iff (!presetn) slip_ev && over);
   cover property (@(posedge pclk) disable iff (!presetn) $rose(cstate == C_SYNC));
   cover property (@(posedge pclk) disable iff (!presetn) $rose(cstate == C_NONCRC));
endmodule

`default_nettype wire

// ### testbench/e1_line_model.sv
// Line side model: free-running recovered clock and framed E1 data, no CRC-4.
// Assumes the receiver samples data on the rising edge of rclk.
`timescale 1ns/1ns
`default_nettype none
module e1_line_model
   import e1_rx_pkg::*;
(
   input wire logic bad_fas, // Send corrupted FAS words
   output logic rclk, // Recovered clock, 80 ns period
   output logic rdata // Line data, set after falling edge
);
   logic [7:0] bit_n;
   logic [3:0] frame_n;
   logic [7:0] cur;
   // Byte carried by one channel of one frame
   function automatic logic [7:0] chan_byte(input logic [4:0] ch, input logic [3:0] fn,
      input logic bad);
      if (ch == 5'h00 && !fn[0]) begin
         return bad ? {1'b1, ~FAS_PATTERN} : {1'b1, FAS_PATTERN};
      end
      if (ch == 5'h00) begin
         return 8'hff;
      end
      if (ch == 5'h10) begin
         return (fn == 4'h0) ? {MFAS_NIBBLE, 4'hf} : 8'hff;
      end
      return 8'h55;
   endfunction
   // Clock runs free; MSB of each channel first
   initial begin
      rclk = 1'b0;
      bit_n = 8'h00;
      frame_n = 4'h0;
      rdata = 1'b1;
      forever begin
         #40 rclk = 1'b1;
         #40 rclk = 1'b0;
         bit_n = bit_n + 8'h01;
         if (bit_n == 8'h00) begin
            frame_n = frame_n + 4'h1;
         end
         cur = chan_byte(bit_n[7:3], frame_n, bad_fas);
         rdata = cur[3'h7 - bit_n[2:0]];
      end
   end
endmodule
`default_nettype wire

// ### testbench/e1_rx_slip_buffer_and_framer_tb_top.sv
// Testbench: APB register tests of framing, interworking and slip reporting.
// Assumes zero-wait APB and a free-running line model.
`timescale 1ns/1ns
`default_nettype none
module e1_rx_slip_buffer_and_framer_tb_top
   import e1_rx_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, st, rd;
   logic rclk, rdata, bp_clk, bad_fas, t1, err;
   logic bp_data, bp_frame, tx_rai, tx_ebit_zero, crc_rx_active, slip_irq;
   int num_errors, n_compared, cycles, bp_half;
   e1_rx_slip_framer #(.TIMEOUT_FRAMES(8)) u_e1_rx_slip_framer (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_recovered_clock(rclk), .rx_line_data(rdata),
      .backplane_bit_clock(bp_clk), .bp_data(bp_data), .bp_frame(bp_frame),
      .tx_rai(tx_rai), .tx_ebit_zero(tx_ebit_zero), .crc_rx_active(crc_rx_active),
      .slip_irq(slip_irq));
   e1_line_model u_e1_line_model (.bad_fas(bad_fas), .rclk(rclk), .rdata(rdata));
   // System clock, 100 MHz
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Backplane clock, period changed to force slips
   initial begin
      bp_clk = 1'b0;
      bp_half = 35;
      forever #(bp_half) bp_clk = ~bp_clk;
   end
   // Verdict and end of run
   task automatic conclude();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         num_errors = num_errors + 1;
         conclude();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; result left in rd and err
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Read status until a bit reaches a value
   task automatic poll(input int idx, input logic v);
      int i;
      for (i = 0; i < 3000; i++) begin
         apb(1'b0, STATUS_ADDR, 32'h0);
         st = rd;
         if (st[idx] === v) break;
         repeat (20) @(posedge pclk);
      end
   endtask
   // Main sequence
   initial begin
      num_errors = 0;
      n_compared = 0;
      cycles = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      bad_fas = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      // Reset values, all framers out of sync
      apb(1'b0, CTRL_ADDR, 32'h0);
      check(rd, 32'(CTRL_RESET));
      apb(1'b0, STATUS_ADDR, 32'h0);
      check(rd, 32'h1c);
      check(32'(tx_rai), 32'h1);
      // Unmapped address is refused
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
      check(32'(err), 32'h1);
      // Unmask slips, interworking on
      apb(1'b1, CTRL_ADDR, 32'h0);
      apb(1'b0, CTRL_ADDR, 32'h0);
      check(rd, 32'h0);
      poll(ST_BASIC_BIT, 1'b0);
      check(32'(st[ST_BASIC_BIT]), 32'h0);
      check(32'(tx_rai), 32'h0);
      // First backplane bit of a read frame carries the TS0 top bit, always one
      while (bp_frame !== 1'b1) @(posedge pclk);
      check(32'(bp_data), 32'h1);
      poll(ST_SIG_BIT, 1'b0);
      check(32'(st[ST_SIG_BIT]), 32'h0);
      // Far end without CRC-4 found after timeout
      poll(ST_NONCRC_BIT, 1'b1);
      check(32'(st[ST_NONCRC_BIT]), 32'h1);
      check(32'(st[ST_CRC_BIT]), 32'h1);
      check(32'({crc_rx_active, tx_ebit_zero}), 32'h1);
      // Fast read side: underflow repeats a frame
      poll(ST_PEND_BIT, 1'b1);
      bp_half = 45;
      check(32'(st[ST_DIR_BIT]), 32'h1);
      check(32'(slip_irq), 32'h1);
      t1 = st[ST_TOGGLE_BIT];
      apb(1'b1, STATUS_ADDR, 32'h40);
      // Pending clears at the access edge, the interrupt flop one edge later
      repeat (2) @(posedge pclk);
      check(32'(slip_irq), 32'h0);
      apb(1'b1, CTRL_ADDR, 32'h1);
      // Slow read side: overflow drops a frame, masked
      poll(ST_PEND_BIT, 1'b1);
      check(32'(st[ST_DIR_BIT]), 32'h0);
      check({31'h0, st[ST_TOGGLE_BIT]}, {31'h0, ~t1});
      check(32'(slip_irq), 32'h0);
      // Bad FAS words drop all alignment
      bad_fas <= 1'b1;
      poll(ST_BASIC_BIT, 1'b1);
      check(32'(st[ST_BASIC_BIT]), 32'h1);
      apb(1'b0, STATUS_ADDR, 32'h0);
      check(32'(rd[ST_SIG_BIT]), 32'h1);
      check(32'(tx_rai), 32'h1);
      conclude();
   end
endmodule
`default_nettype wire
